//--- shared/npi_pkg.sv
/*
  Shared constants for the nested priority interrupt controller: register
  offsets, field positions, reset values, source count and timing counts.
  Assumes a 32-bit classic Wishbone slave with byte addresses.
*/
package npi_pkg;

  // sources and levels
  localparam int unsigned NUM_SRC    = 8;
  localparam int unsigned KEY_SRC    = 7;  // key detector feeds this source
  localparam int unsigned LVL_W      = 3;
  localparam int unsigned NUM_LVL    = 8;
  localparam int unsigned NUM_KEY    = 8;

  // register map (byte addresses)
  localparam logic [31:0] ICR_BASE   = 32'hFFFFF100;  // 8 words, one per source
  localparam logic [31:0] STAT_ADDR  = 32'hFFFFF1F0;
  localparam logic [31:0] KEY_ADDR   = 32'hFFFFF300;

  // interrupt control register fields
  localparam int unsigned ICR_FLAG   = 7;
  localparam int unsigned ICR_MASK   = 6;
  localparam int unsigned ICR_PRIO_L = 0;
  localparam int unsigned ICR_PRIO_H = 2;

  // status register fields
  localparam int unsigned STAT_ISV_L = 0;
  localparam int unsigned STAT_ISV_H = 7;
  localparam int unsigned STAT_NMI   = 8;
  localparam int unsigned STAT_VALID = 9;
  localparam int unsigned STAT_BLOCK = 10;

  // reset values
  localparam logic             MASK_RST = 1'b1;
  localparam logic [2:0]       PRIO_RST = 3'h7;
  localparam logic [7:0]       KEY_RST  = 8'h00;
  localparam logic [7:0]       ISV_RST  = 8'h00;

  // timing: least response time, in clocks, and derived cycle counts
  localparam int unsigned RESP_CLK   = 4;
  localparam int unsigned RESP_CYC   = RESP_CLK;
  localparam logic [2:0]  AGE_READY  = 3'(RESP_CYC - 1);
  localparam logic [3:0]  LVL_NONE   = 4'h8;  // nothing in service

endpackage

//--- src/npi_key_detect.sv
/*
  Eight-input key detector: synchronises the key input pins and pulses a
  single request when the AND of all enabled pins falls.
  Assumes key pins are asynchronous to ref_clk.
*/
`timescale 1ns/1ns
module npi_key_detect (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // pins and enables
  input  wire logic [7:0] keyInputPin,
  input  wire logic [7:0] keyEnable,
  // request out
  output logic            keyPulse
);

  logic [7:0] keySync1_q;
  logic [7:0] keySync2_q;
  logic       allHigh_q;
  wire  logic allHighNow;

  // a disabled pin reads as high, so it never holds the gate low
  assign allHighNow = &(keySync2_q | ~keyEnable);
  assign keyPulse   = allHigh_q & ~allHighNow;

  // two-stage synchroniser, then the previous gate level
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      keySync1_q <= 8'hFF;
      keySync2_q <= 8'hFF;
      allHigh_q  <= 1'b1;
    end else if (ce) begin
      keySync1_q <= keyInputPin;
      keySync2_q <= keySync1_q;
      allHigh_q  <= allHighNow;
    end
  end

endmodule

//--- src/npi_prio_select.sv
/*
  Combinational priority picker: among eligible sources returns the one
  with the numerically lowest level, lowest index first on a tie.
  Assumes levels are packed three bits per source.
*/
`timescale 1ns/1ns
module npi_prio_select (
  // candidates
  input  wire logic [7:0]  eligible,
  input  wire logic [23:0] levels,
  // winner
  output logic             found,
  output logic [2:0]       winIdx,
  output logic [2:0]       winLvl
);

  // scan downward so a lower index with an equal level overwrites
  always_comb begin
    found  = 1'b0;
    winIdx = 3'h0;
    winLvl = 3'h7;
    for (int i = npi_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i] && (!found || levels[i*3 +: 3] <= winLvl)) begin
        found  = 1'b1;
        winIdx = 3'(i);
        winLvl = levels[i*3 +: 3];
      end
    end
  end

endmodule

//--- src/npi_irq_ctrl.sv
/*
  Nested priority interrupt controller with a key-return request source.
  Holds per-source control registers, tracks the levels in service and
  the non-maskable window, and offers one request at a time to the CPU.
  Assumes a classic Wishbone master on ref_clk, CPU strobes on ref_clk,
  and peripheral request pulses on ref_clk; key pins are asynchronous.
*/
// Overview of operation
// - A strictly higher level preempts the running maskable routine.
// - Equal or lower level than the one in service stays pending.
// - Nested acknowledge only while the interrupt disable flag is 0.
// - Each source has a 3-bit level; 0 highest, 7 lowest.
// - Reset leaves every source masked at level 7.
// - A suspended routine resumes only after the higher one returns.
// - A pending request is taken only after the current return.
// - During a non-maskable routine no maskable request is acknowledged.
// - A request is offered no sooner than 4 clocks after it arrives.
// - Standby, bus or register accesses may delay the response.
// - Nothing is acknowledged between a non-sample instruction and next.
// - Interrupt, mask, power and protection writes are non-sample.
// - Falling edge on an enabled key pin raises the key request.
// - With any enabled key pin low, other falling edges are ignored.
// - Key enable register: eight bits, 1 enables, resets to zero.
`timescale 1ns/1ns
module npi_irq_ctrl (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // request sources
  input  wire logic [6:0]  irqSource,
  input  wire logic [7:0]  keyInputPin,
  // cpu side
  input  wire logic        interruptDisableFlag,
  input  wire logic        cpuAccept,
  input  wire logic        returnFromInterrupt,
  input  wire logic        nmiEnter,
  input  wire logic        nonSampleInstr,
  input  wire logic        instrDone,
  input  wire logic        responseStall,
  output logic             irqValid,
  output logic      [2:0]  irqCode,
  output logic      [2:0]  irqLevel
);

  // control registers
  logic [7:0]  flag_q;
  logic [7:0]  mask_q;
  logic [2:0]  prio_q [8];
  logic [2:0]  age_q  [8];
  logic [7:0]  keyReturnEnable_q;
  logic [7:0]  inService_q;
  logic        nmiActive_q;
  logic        block_q;
  logic        irqValid_q;
  logic [2:0]  irqCode_q;
  logic [2:0]  irqLevel_q;
  logic        ack_q;
  logic [31:0] datOut_q;

  // bus decode
  wire logic        busReq;
  wire logic        busWrite;
  wire logic        hitIcr;
  wire logic        hitStat;
  wire logic        hitKey;
  wire logic [2:0]  icrIdx;
  wire logic        lane0;
  wire logic [31:0] readWord;
  wire logic [31:0] icrWord [8];

  assign busReq   = wb_cyc_i & wb_stb_i;
  // a write lands on the edge where the master samples ack
  assign busWrite = busReq & ack_q & wb_we_i;
  assign icrIdx   = wb_adr_i[4:2];
  assign lane0    = wb_sel_i[0];
  assign hitIcr   = (wb_adr_i[31:5] == npi_pkg::ICR_BASE[31:5])
                    && (wb_adr_i[1:0] == 2'b00);
  assign hitStat  = (wb_adr_i == npi_pkg::STAT_ADDR);
  assign hitKey   = (wb_adr_i == npi_pkg::KEY_ADDR);

  // read selection; unmapped addresses read as zero
  assign readWord = hitIcr  ? icrWord[icrIdx] :
                    hitStat ? {21'h000000, block_q, irqValid_q, nmiActive_q,
                               inService_q} :
                    hitKey  ? {24'h000000, keyReturnEnable_q} :
                              32'h00000000;

  // key detector and its request
  wire logic keyPulse;

  npi_key_detect u_key (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .ce          (ce),
    .keyInputPin (keyInputPin),
    .keyEnable   (keyReturnEnable_q),
    .keyPulse    (keyPulse)
  );

  wire logic [7:0] srcPulse;

  assign srcPulse = {keyPulse, irqSource};

  // per-source eligibility and packed levels
  wire logic [7:0]  eligible;
  wire logic [23:0] levelsPacked;
  wire logic [7:0]  swWr;
  wire logic [7:0]  accClr;

  genvar g;
  generate
    for (g = 0; g < npi_pkg::NUM_SRC; g++) begin : gSrc
      assign icrWord[g] = {24'h000000, flag_q[g], mask_q[g], 3'b000,
                           prio_q[g]};
      assign levelsPacked[g*3 +: 3] = prio_q[g];
      // a request is offered only once it has aged enough
      assign eligible[g] = flag_q[g] & ~mask_q[g]
                           & (age_q[g] == npi_pkg::AGE_READY);
      assign swWr[g]   = busWrite & hitIcr & lane0 & (icrIdx == 3'(g));
      assign accClr[g] = cpuAccept & irqValid_q & (irqCode_q == 3'(g));

      // flag: a new request wins over any clear in the same cycle
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          flag_q[g] <= 1'b0;
          mask_q[g] <= npi_pkg::MASK_RST;
          prio_q[g] <= npi_pkg::PRIO_RST;
        end else if (ce) begin
          if (srcPulse[g]) begin
            flag_q[g] <= 1'b1;
          end else if (swWr[g]) begin
            flag_q[g] <= wb_dat_i[npi_pkg::ICR_FLAG];
          end else if (accClr[g]) begin
            flag_q[g] <= 1'b0;
          end
          if (swWr[g]) begin
            mask_q[g] <= wb_dat_i[npi_pkg::ICR_MASK];
            prio_q[g] <= wb_dat_i[npi_pkg::ICR_PRIO_H:npi_pkg::ICR_PRIO_L];
          end
        end
      end

      // age since the flag rose, saturating at the ready count
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          age_q[g] <= 3'h0;
        end else if (ce) begin
          if (!flag_q[g] || srcPulse[g]) begin
            age_q[g] <= 3'h0;
          end else if (age_q[g] != npi_pkg::AGE_READY) begin
            age_q[g] <= age_q[g] + 3'h1;
          end
        end
      end
    end
  endgenerate

  // winner among eligible sources
  wire logic       found;
  wire logic [2:0] winIdx;
  wire logic [2:0] winLvl;

  npi_prio_select u_sel (
    .eligible (eligible),
    .levels   (levelsPacked),
    .found    (found),
    .winIdx   (winIdx),
    .winLvl   (winLvl)
  );

  // level now in service: lowest set bit, or none
  logic [3:0] curLevel;

  always_comb begin
    curLevel = npi_pkg::LVL_NONE;
    for (int i = npi_pkg::NUM_LVL - 1; i >= 0; i--) begin
      if (inService_q[i]) begin
        curLevel = 4'(i);
      end
    end
  end

  // register writes that must hold off sampling for one instruction
  wire logic regNonSample;

  assign regNonSample = busWrite
                        & ((hitIcr & lane0) | (hitKey & lane0));

  // offer gate: strictly higher level, enabled, no nmi, no blocking window
  wire logic higher;
  wire logic offerOk;

  assign higher  = ({1'b0, winLvl} < curLevel);
  // equal or lower levels simply fail the compare and stay pending
  assign offerOk = found & higher
                   & ~interruptDisableFlag
                   & ~nmiActive_q
                   & ~block_q & ~nonSampleInstr & ~regNonSample
                   & ~responseStall;

  // return clears the highest-priority level in service, or the nmi
  wire logic [7:0] retClear;
  wire logic       retMask;

  assign retMask  = returnFromInterrupt & ~nmiActive_q;
  assign retClear = retMask ? (inService_q & (~inService_q + 8'h01))
                            : 8'h00;

  // in-service levels: accept sets, return clears
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      inService_q <= npi_pkg::ISV_RST;
    end else if (ce) begin
      if (cpuAccept && irqValid_q) begin
        inService_q <= (inService_q & ~retClear)
                       | (8'h01 << irqLevel_q);
      end else begin
        inService_q <= inService_q & ~retClear;
      end
    end
  end

  // non-maskable window from entry until its own return
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nmiActive_q <= 1'b0;
    end else if (ce) begin
      if (nmiEnter) begin
        nmiActive_q <= 1'b1;
      end else if (returnFromInterrupt) begin
        nmiActive_q <= 1'b0;
      end
    end
  end

  // sampling gap: closes when the following instruction completes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      block_q <= 1'b0;
    end else if (ce) begin
      if (nonSampleInstr || regNonSample) begin
        block_q <= 1'b1;
      end else if (instrDone) begin
        block_q <= 1'b0;
      end
    end
  end

  // offer to the cpu; dropped in the cycle after it is accepted
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqValid_q <= 1'b0;
      irqCode_q  <= 3'h0;
      irqLevel_q <= npi_pkg::PRIO_RST;
    end else if (ce) begin
      irqValid_q <= offerOk & ~(cpuAccept & irqValid_q);
      if (offerOk) begin
        irqCode_q  <= winIdx;
        irqLevel_q <= winLvl;
      end
    end
  end

  // key enable register, byte lane 0 only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      keyReturnEnable_q <= npi_pkg::KEY_RST;
    end else if (ce) begin
      if (busWrite && hitKey && lane0) begin
        keyReturnEnable_q <= wb_dat_i[7:0];
      end
    end
  end

  // bus answer one cycle after request; unmapped still acked with zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_q    <= 1'b0;
      datOut_q <= 32'h00000000;
    end else if (ce) begin
      ack_q <= busReq & ~ack_q;
      if (busReq && !ack_q) begin
        datOut_q <= readWord;
      end
    end
  end

  // outputs straight from flip-flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = datOut_q;
  assign irqValid = irqValid_q;
  assign irqCode  = irqCode_q;
  assign irqLevel = irqLevel_q;

endmodule

//--- sim/npi_irq_monitor.sv
/*
  Checker for the interrupt controller's bus and cpu-side ports.
  Assumes one clock, ref_clk, and the synchronous reset rst.
*/
`timescale 1ns/1ns
module npi_irq_monitor (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // register bus
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // sources and cpu side
  input wire logic [6:0] irqSource,
  input wire logic       interruptDisableFlag,
  input wire logic       cpuAccept,
  input wire logic       returnFromInterrupt,
  input wire logic       nmiEnter,
  input wire logic       nonSampleInstr,
  input wire logic       instrDone,
  input wire logic       responseStall,
  input wire logic       irqValid,
  input wire logic [2:0] irqCode
);
  logic [6:0] s1_q, s2_q, s3_q, s4_q;
  logic       nmi_q, gap_q;
  // source 7 is the key path, whose pulses are not visible here
  wire  [7:0] recent = {1'h0, s1_q | s2_q | s3_q | s4_q};

  // last four source pulses and shadows of the two blocking windows
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {s1_q, s2_q, s3_q, s4_q} <= 28'h0;
      nmi_q <= 1'h0;
      gap_q <= 1'h0;
    end else begin
      {s1_q, s2_q, s3_q, s4_q} <= {irqSource, s1_q, s2_q, s3_q};
      nmi_q <= nmiEnter | (nmi_q & ~returnFromInterrupt);
      gap_q <= nonSampleInstr | (gap_q & ~instrDone);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // bus request, then one ack pulse
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_ack_one_pulse: assert property (s_req |=> s_ack)
    else $error("ack missing or longer than one cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_disable_holds: assert property (
    $rose(irqValid) |-> !$past(interruptDisableFlag))
    else $error("offer while interrupts disabled");
  a_nmi_window: assert property (
    $rose(irqValid) |-> !$past(nmi_q))
    else $error("offer inside non-maskable routine");
  a_nosample_gap: assert property (
    $rose(irqValid) |-> !$past(gap_q))
    else $error("offer after non-sample instruction");
  a_stall_holds: assert property (
    responseStall && !irqValid |=> !irqValid)
    else $error("offer during response stall");
  a_min_response: assert property (
    $rose(irqValid) |-> !recent[irqCode])
    else $error("offer sooner than 4 clocks after request");
  a_accept_drops: assert property (
    cpuAccept && irqValid |=> !irqValid)
    else $error("offer stands after accept");
endmodule

bind npi_irq_ctrl npi_irq_monitor npi_irq_monitor_i (.*);

//--- sim/npi_cpu_model.sv
/*
  Behavioural cpu core: takes a standing offer after lag cycles.
  Assumes the bench drives returns and the blocking strobes itself.
*/
`timescale 1ns/1ns
module npi_cpu_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // offer and test controls
  input  wire logic       irqValid,
  input  wire logic       takeEn,
  input  wire logic [3:0] lag,
  // take strobe
  output logic            cpuAccept
);
  logic [3:0] wait_q;

  // one-cycle take; never repeated while the same offer still stands
  always_ff @(posedge ref_clk) begin
    if (rst || !irqValid || cpuAccept) begin
      wait_q    <= 4'h0;
      cpuAccept <= 1'h0;
    end else if (takeEn && wait_q == lag) begin
      cpuAccept <= 1'h1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

//--- sim/testbench.sv
/*
  Self-checking bench: registers, nesting, blocking, ties and key pins.
  Assumes package, design, cpu model and checker are compiled first.
*/
`timescale 1ns/1ns
module testbench;
  localparam logic [3:0] RET = 4'h1, DONE = 4'h2, NOS = 4'h4, NMI = 4'h8;
  // design signals, named as the ports for the hookup below
  logic        ref_clk = 1'h0, rst = 1'h1, ce = 1'h1;
  logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [6:0]  irqSource = 7'h0;
  logic [7:0]  keyInputPin = 8'hFF;
  logic        interruptDisableFlag = 1'h0, responseStall = 1'h0;
  logic        nmiEnter = 1'h0, nonSampleInstr = 1'h0;
  logic        instrDone = 1'h0, returnFromInterrupt = 1'h0;
  logic        wb_ack_o, cpuAccept, irqValid, seen, takeEn = 1'h0;
  logic [2:0]  irqCode, irqLevel;
  logic [3:0]  lag = 4'h0;
  logic [5:0]  got;
  int          lat, errors = 0, n_checks = 0;

  npi_irq_ctrl  npi_irq_ctrl_i (.*);
  npi_cpu_model npi_cpu_model_i (.*);

  always #10 ref_clk = ~ref_clk;

  task check(input logic [31:0] val, input logic [31:0] exp);
    n_checks++;
    if (val !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, val, exp);
    end
  endtask

  task summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // classic cycle; read data is taken at the edge that sees ack
  task wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    check(n < 20, 1'h1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask

  // one-cycle cpu strobes
  task strobe(input logic [3:0] s);
    @(posedge ref_clk);
    {nmiEnter, nonSampleInstr, instrDone, returnFromInterrupt} <= s;
    @(posedge ref_clk);
    {nmiEnter, nonSampleInstr, instrDone, returnFromInterrupt} <= 4'h0;
  endtask

  // a source is never pulsed again within 4 clocks
  task fire(input logic [6:0] s);
    @(posedge ref_clk);
    irqSource <= s;
    @(posedge ref_clk);
    irqSource <= 7'h0;
  endtask

  // control write, then the instruction after it completes
  task cfg(input int n, input logic [7:0] v);
    wb(1'h1, npi_pkg::ICR_BASE + 32'(4 * n), {24'h0, v});
    strobe(DONE);
  endtask

  // wait for an offer, note it, then wait until the model has taken it
  task offer;
    lat = 0;
    do begin
      @(posedge ref_clk);
      lat++;
    end while (irqValid !== 1'h1 && lat < 40);
    check(lat < 40, 1'h1);
    got = {irqCode, irqLevel};
    repeat (20) if (irqValid === 1'h1) @(posedge ref_clk);
  endtask

  task quiet(input int n);
    seen = 1'h0;
    repeat (n) begin
      @(posedge ref_clk);
      seen = seen | irqValid;
    end
  endtask

  task regs_reset;
    for (int i = 0; i < 8; i++) begin
      wb(1'h0, npi_pkg::ICR_BASE + 32'(4 * i), 32'h0);
      check(rd, 32'h47);
    end
    wb(1'h0, npi_pkg::KEY_ADDR, 32'h0);
    check(rd, 32'h0);
    wb(1'h1, npi_pkg::KEY_ADDR, 32'hA5);
    strobe(DONE);
    wb(1'h0, npi_pkg::KEY_ADDR, 32'h0);
    check(rd, 32'hA5);
    wb(1'h0, 32'hFFFFF200, 32'h0);
    check(rd, 32'h0);
  endtask

  task basic;
    cfg(2, 8'h03);
    fire(7'h04);
    offer();
    check(got, {3'h2, 3'h3});
    check(lat >= 5, 1'h1);
    wb(1'h0, npi_pkg::STAT_ADDR, 32'h0);
    check(rd, 32'h08);
  endtask

  // level 3 in service: level 5 waits, level 1 preempts
  task nest;
    cfg(4, 8'h05);
    cfg(1, 8'h01);
    fire(7'h10);
    quiet(10);
    check(seen, 1'h0);
    fire(7'h02);
    offer();
    check(got, {3'h1, 3'h1});
    strobe(RET);
    quiet(8);
    check(seen, 1'h0);
    strobe(RET);
    offer();
    check(got, {3'h4, 3'h5});
    strobe(RET);
  endtask

  // each blocker in turn; the partner takes the offer ever more slowly
  task holds;
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      case (k)
        0: interruptDisableFlag <= 1'h1;
        1: nmiEnter <= 1'h1;
        2: nonSampleInstr <= 1'h1;
        default: responseStall <= 1'h1;
      endcase
      @(posedge ref_clk);
      {nmiEnter, nonSampleInstr} <= 2'h0;
      fire(7'h04);
      quiet(8);
      check(seen, 1'h0);
      {interruptDisableFlag, responseStall} <= 2'h0;
      lag <= 4'(k);
      strobe(k == 1 ? RET : DONE);
      offer();
      check(got, {3'h2, 3'h3});
      strobe(RET);
    end
    lag <= 4'h0;
  endtask

  // equal levels: index order, and equal to the one in service waits
  task tie;
    cfg(0, 8'h03);
    cfg(3, 8'h03);
    fire(7'h09);
    offer();
    check(got, {3'h0, 3'h3});
    fire(7'h04);
    quiet(8);
    check(seen, 1'h0);
    strobe(RET);
    offer();
    check(got, {3'h2, 3'h3});
    strobe(RET);
    offer();
    check(got, {3'h3, 3'h3});
    strobe(RET);
    // with the clock enable low a source pulse must leave no trace
    ce <= 1'h0;
    fire(7'h01);
    ce <= 1'h1;
    quiet(10);
    check(seen, 1'h0);
  endtask

  task keys;
    @(posedge ref_clk);
    interruptDisableFlag <= 1'h1;
    wb(1'h1, npi_pkg::KEY_ADDR, 32'h03);
    cfg(7, 8'h06);
    interruptDisableFlag <= 1'h0;
    keyInputPin <= 8'hFE;
    offer();
    check(got, {3'h7, 3'h6});
    strobe(RET);
    keyInputPin <= 8'hFC;
    quiet(10);
    check(seen, 1'h0);
    keyInputPin <= 8'hFF;
    quiet(6);
    keyInputPin <= 8'hFB;
    quiet(10);
    check(seen, 1'h0);
    keyInputPin <= 8'hFD;
    offer();
    check(got, {3'h7, 3'h6});
    strobe(RET);
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'h0;
    takeEn <= 1'h1;
    regs_reset;
    basic;
    nest;
    holds;
    tie;
    keys;
    summarize;
  end

  // the tests need about 350 cycles; the 10000-cycle limit allows many times that
  initial begin
    #200000;
    errors++;
    summarize;
  end
endmodule
